// ===== jack_partner.sv
// partner: one audio jack with a plug switch
// assumes the sense pin is sampled on the block clock
`timescale 1ns/1ps
module jack_partner (
  input wire logic plugged,
  output logic level
);
  // empty jack pulled down by load, plug pulled up
  assign level = plugged ? 1'b1 : 1'b0;
endmodule

// ===== jack_sense_checker.sv
// checker: port relations of the jack sense block
// assumes a bind onto jack_sense_ctrl, one clock
`timescale 1ns/1ps
module jack_sense_checker #(
  parameter int unsigned hold_cycles = 20
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic soft_rst,
  input wire logic sense_pin_a,
  input wire logic sense_pin_b,
  input wire jack_sense_pkg::reg_req_t req,
  input wire logic downmix_control,
  input wire logic spread_force,
  input wire logic [15:0] rdata,
  input wire logic system_irq,
  input wire logic irq_slot12,
  input wire logic irq_slot6,
  input wire jack_sense_pkg::forced_silence_t forced_silence,
  input wire jack_sense_pkg::forced_silence_t output_mute,
  input wire logic eq_bypass,
  input wire logic downmix_active,
  input wire logic spread_active
);
  import jack_sense_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_dmx_held; downmix_control [*2]; endsequence
  sequence s_spr_held; spread_force [*2]; endsequence
  a_path_excl: assert property (!(irq_slot12 && irq_slot6))
    else $error("irq on both slots");
  a_rdata_idle: assert property (!$past(req.rd) |-> rdata == 16'h0000)
    else $error("read data outside read slot");
  a_silence_mutes: assert property ((forced_silence & ~output_mute) == 0)
    else $error("forced mute not muting");
  a_irq_sticky: assert property ($fell(system_irq) |-> $past(soft_rst, 2)
    || ($past(req.wr, 2) && $past(req.addr, 2) == 8'h72))
    else $error("irq dropped without clear");
  a_dmx_force: assert property (s_dmx_held |-> downmix_active)
    else $error("forced downmix missing");
  a_spr_force: assert property (s_spr_held |-> spread_active)
    else $error("forced spread missing");
  a_eq_cause: assert property (eq_bypass |->
    $past(sense_pin_a) || $past(sense_pin_b))
    else $error("eq bypass without pin");
  a_dmx_cause: assert property (downmix_active |-> $past(downmix_control)
    || $past(sense_pin_a) || $past(sense_pin_b))
    else $error("downmix without cause");
  a_spr_cause: assert property (spread_active |-> $past(spread_force)
    || ($past(sense_pin_a) && $past(sense_pin_b)))
    else $error("spread without cause");
endmodule
bind jack_sense_ctrl jack_sense_checker #(.hold_cycles(hold_cycles)) i_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .soft_rst(soft_rst),
  .sense_pin_a(sense_pin_a), .sense_pin_b(sense_pin_b), .req(req),
  .downmix_control(downmix_control), .spread_force(spread_force),
  .rdata(rdata), .system_irq(system_irq), .irq_slot12(irq_slot12),
  .irq_slot6(irq_slot6), .forced_silence(forced_silence),
  .output_mute(output_mute), .eq_bypass(eq_bypass),
  .downmix_active(downmix_active), .spread_active(spread_active));

// ===== jack_sense_ctrl.sv
// jack sense control: registers, irq flags, mute matrix, feature gates
// assumes synchronous sense pins with external pull-downs, 16-bit port
// Function
// - pin a event sets its irq flag; stays until software writes zero or a soft reset
// - pin b has an identical sticky irq flag
// - system interrupt is OR of both sticky flags
// - software writing one sets a flag and raises interrupt
// - level bits read live pin state; writes ignored
// - mode bit per pin: zero jack sense, one interrupt
// - with filter on, pin high only after more than 278 ms
// - per-pin enable plus sensed high bypasses equalizer
// - code one: front and center follow pin b
// - code two: headphone, center follow pin b; mono opposite
// - code four: headphone active; front/center/mono by both pins
// - code five: three outputs follow pin b; mono when both low
// - forced mute or forced active overrides volume mute
// - empty jack reads zero, inserted plug reads one
// - pin a downmix enable and pin a high activate downmix
// - spread enable with both pins high, or force, spreads
// - path select routes irq to slot 12 bit 0 or slot 6
// - serial configuration survives soft reset
// - jack register fully read/write except the level bits
// - downmix force one always downmixes, else pin gated
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module jack_sense_ctrl #(
  parameter int unsigned hold_cycles = jack_sense_pkg::qualify_cycles
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic soft_rst,
  input wire logic sense_pin_a,
  input wire logic sense_pin_b,
  input wire jack_sense_pkg::reg_req_t req,
  input wire logic downmix_control,
  input wire logic spread_force,
  input wire jack_sense_pkg::forced_silence_t volume_mute,
  output logic [15:0] rdata,
  output logic system_irq,
  output logic irq_slot12,
  output logic irq_slot6,
  output jack_sense_pkg::forced_silence_t forced_silence,
  output jack_sense_pkg::forced_silence_t output_mute,
  output logic eq_bypass,
  output logic downmix_active,
  output logic spread_active
);
  import jack_sense_pkg::*;

  logic [15:0] js_reg;
  logic [15:0] serial_reg;
  logic [1:0] sensed;
  logic [1:0] sensed_d_reg;
  logic [1:0] raw_pin;
  logic [1:0] irq_event;
  logic [2:0] jack_mute_select;
  forced_silence_t forced_silence_next;
  forced_silence_t factive_next;
  logic wr_js;
  logic wr_sc;

  assign raw_pin = {sense_pin_b, sense_pin_a};
  assign wr_js = req.wr && (req.addr == jack_sense_control_status_off);
  assign wr_sc = req.wr && (req.addr == serial_configuration_off);
  assign jack_mute_select = js_reg[bit_mute_lo +: 3];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : pin_gen
      pin_qualifier #(
        .hold_cycles(hold_cycles)
      ) u_qual (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin(raw_pin[g]),
        .qualify_enable(js_reg[bit_a_qualify + g]),
        .sensed(sensed[g])
      );
      // interrupt mode pins raise on a qualified rising edge
      assign irq_event[g] = js_reg[bit_a_mode + g] &&
                            sensed[g] && !sensed_d_reg[g];
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sensed_d_reg <= 2'b00;
    end else begin
      sensed_d_reg <= sensed;
    end
  end

  // jack register: soft reset clears it like a full reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst || soft_rst) begin
      js_reg <= jack_sense_reset;
    end else begin
      if (wr_js) begin
        js_reg <= req.wdata;
      end
      // hardware set beats a software clear in the same cycle
      if (irq_event[0]) begin
        js_reg[bit_a_irq] <= 1'b1;
      end
      if (irq_event[1]) begin
        js_reg[bit_b_irq] <= 1'b1;
      end
      // level bits reload from the live pins every cycle; writes never stick
      js_reg[bit_a_level] <= sensed[0];
      js_reg[bit_b_level] <= sensed[1];
    end
  end

  // serial config: only a full reset restores it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      serial_reg <= serial_configuration_reset;
    end else if (wr_sc) begin
      serial_reg <= req.wdata & serial_cfg_writable;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata <= 16'h0;
    end else if (req.rd) begin
      unique case (req.addr)
        jack_sense_control_status_off: begin
          rdata <= {js_reg[15:4], sensed, js_reg[1:0]};
        end
        serial_configuration_off: begin
          rdata <= serial_reg;
        end
        jack_output_state_off: begin
          rdata <= {8'h0, forced_silence, output_mute};
        end
        default: begin
          rdata <= 16'h0;
        end
      endcase
    end else begin
      rdata <= 16'h0;
    end
  end

  // mute matrix; index b is pin b, a is pin a
  always_comb begin
    forced_silence_next = '0;
    factive_next = '0;
    unique case (jack_mute_select)
      3'h0: begin
        factive_next = 4'hf;
      end
      3'h1: begin
        factive_next.headphone_output = 1'b1;
        factive_next.mono_output = 1'b1;
        factive_next.front_output = sensed[1];
        factive_next.center_sub_output = sensed[1];
        forced_silence_next.front_output = !sensed[1];
        forced_silence_next.center_sub_output = !sensed[1];
      end
      3'h2: begin
        factive_next.front_output = 1'b1;
        factive_next.headphone_output = sensed[1];
        factive_next.center_sub_output = sensed[1];
        factive_next.mono_output = !sensed[1];
        forced_silence_next.headphone_output = !sensed[1];
        forced_silence_next.center_sub_output = !sensed[1];
        forced_silence_next.mono_output = sensed[1];
      end
      3'h4: begin
        factive_next.headphone_output = 1'b1;
        factive_next.front_output = !sensed[1] && sensed[0];
        factive_next.center_sub_output = !sensed[1] && sensed[0];
        factive_next.mono_output = !sensed[1] && !sensed[0];
        forced_silence_next.front_output = sensed[1] || !sensed[0];
        forced_silence_next.center_sub_output = sensed[1] || !sensed[0];
        forced_silence_next.mono_output = sensed[1] || sensed[0];
      end
      3'h5: begin
        factive_next.headphone_output = sensed[1];
        factive_next.front_output = sensed[1];
        factive_next.center_sub_output = sensed[1];
        factive_next.mono_output = !sensed[1] && !sensed[0];
        forced_silence_next.headphone_output = !sensed[1];
        forced_silence_next.front_output = !sensed[1];
        forced_silence_next.center_sub_output = !sensed[1];
        forced_silence_next.mono_output = sensed[1] || sensed[0];
      end
      default: begin
        // reserved codes leave volume registers in charge
        forced_silence_next = '0;
        factive_next = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      forced_silence <= '0;
      output_mute <= '0;
    end else begin
      forced_silence <= forced_silence_next;
      // forcing beats the volume mute bit either way
      output_mute <= forced_silence_next | (volume_mute & ~factive_next);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      system_irq <= 1'b0;
      irq_slot12 <= 1'b0;
      irq_slot6 <= 1'b0;
    end else begin
      system_irq <= js_reg[bit_a_irq] | js_reg[bit_b_irq];
      irq_slot12 <= (js_reg[bit_a_irq] | js_reg[bit_b_irq]) &&
                    !serial_reg[bit_irq_path];
      irq_slot6 <= (js_reg[bit_a_irq] | js_reg[bit_b_irq]) &&
                   serial_reg[bit_irq_path];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      eq_bypass <= 1'b0;
      downmix_active <= 1'b0;
      spread_active <= 1'b0;
    end else begin
      eq_bypass <= |(js_reg[bit_a_eqb +: 2] & sensed);
      downmix_active <= downmix_control ||
                        |(js_reg[bit_a_dmx +: 2] & sensed);
      spread_active <= spread_force ||
                       (js_reg[bit_spread] && &sensed);
    end
  end
endmodule

// ===== jack_sense_ctrl_tb.sv
// testbench: register port, two jacks, volume mutes
// assumes jack_partner models and a 25 MHz clock
`timescale 1ns/1ps
module jack_sense_ctrl_tb;
  import jack_sense_pkg::*;
  logic ref_clk = 0, sys_rst = 1, soft_rst = 0, plug_a = 0, plug_b = 0;
  logic sense_pin_a, sense_pin_b, downmix_control = 0, spread_force = 0;
  reg_req_t req = '0;
  forced_silence_t volume_mute = '0, forced_silence, output_mute;
  logic [15:0] rdata;
  logic system_irq, irq_slot12, irq_slot6;
  logic eq_bypass, downmix_active, spread_active;
  logic [15:0] exp_q[$];
  logic rd_seen = 0;
  logic [31:0] lf = 32'haaf3;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  always #20 ref_clk = ~ref_clk;
  jack_partner i_pa (.plugged(plug_a), .level(sense_pin_a));
  jack_partner i_pb (.plugged(plug_b), .level(sense_pin_b));
  // short filter keeps the run small
  jack_sense_ctrl #(.hold_cycles(20)) i_dut (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .soft_rst(soft_rst), .sense_pin_a(sense_pin_a),
    .sense_pin_b(sense_pin_b), .req(req), .rdata(rdata),
    .downmix_control(downmix_control), .spread_force(spread_force),
    .volume_mute(volume_mute), .system_irq(system_irq),
    .irq_slot12(irq_slot12), .irq_slot6(irq_slot6),
    .forced_silence(forced_silence), .output_mute(output_mute),
    .eq_bypass(eq_bypass), .downmix_active(downmix_active),
    .spread_active(spread_active));
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // random source for volume mutes
  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [15:0] d);
    @(posedge ref_clk);
    req <= '{a, d, w, !w};
    @(posedge ref_clk);
    req <= '{a, d, 1'b0, 1'b0};
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] e);
    exp_q.push_back(e);
    bus(0, a, 16'h0000);
    @(posedge ref_clk);
  endtask
  function automatic logic [7:0] mtab(int c, logic b, logic a);
    case (c)
      0: return 8'h0f;
      1: return b ? 8'h0f : 8'h69;
      2: return b ? 8'h1e : 8'ha5;
      4: return b ? 8'h78 : (a ? 8'h1e : 8'h69);
      5: return b ? 8'h1e : (a ? 8'hf0 : 8'he1);
      default: return 8'h00;
    endcase
  endfunction
  // results checked in the cycle after the read strobe
  always @(posedge ref_clk) begin
    cyc++;
    if (rd_seen)
      chk("rdata", rdata, exp_q.pop_front());
    rd_seen <= req.rd;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    logic [7:0] m;
    tick(10);
    sys_rst <= 0;
    rd(8'h72, 16'h0000);
    rd(8'h74, 16'h1001);
    bus(1, 8'h72, 16'hfff3);
    rd(8'h72, 16'hfff3);
    bus(1, 8'h74, 16'hffff);
    tick(3);
    chk("slot6", irq_slot6, 1);
    soft_rst <= 1;
    tick(3);
    soft_rst <= 0;
    rd(8'h72, 16'h0000);
    rd(8'h74, 16'hfd77);
    $display("registers done");
    for (int i = 0; i < 2; i++) begin
      bus(1, 8'h74, 16'(i) << 4);
      bus(1, 8'h72, 16'(1) << i);
      tick(3);
      chk("irq", system_irq, 1);
      chk("slot12", irq_slot12, !i);
      rd(8'h72, 16'(1) << i);
      bus(1, 8'h72, 16'h0000);
      tick(3);
      chk("irq", system_irq, 0);
    end
    plug_a <= 1;
    plug_b <= 1;
    tick(3);
    rd(8'h72, 16'h000c);
    bus(1, 8'h72, 16'ha100);
    tick(3);
    chk("eq", eq_bypass, 1);
    chk("dmx", downmix_active, 1);
    chk("spr", spread_active, 1);
    plug_b <= 0;
    tick(4);
    chk("spr", spread_active, 0);
    plug_a <= 0;
    spread_force <= 1;
    tick(4);
    chk("eq", eq_bypass, 0);
    chk("dmx", downmix_active, 0);
    chk("spr", spread_active, 1);
    downmix_control <= 1;
    spread_force <= 0;
    tick(3);
    chk("dmx", downmix_active, 1);
    downmix_control <= 0;
    $display("gating done");
    bus(1, 8'h72, 16'h0050);
    plug_a <= 1;
    tick(15);
    plug_a <= 0;
    tick(2);
    plug_a <= 1;
    tick(15);
    chk("irq", system_irq, 0);
    tick(15);
    chk("irq", system_irq, 1);
    $display("filter done");
    for (int c = 0; c < 8; c++)
      for (int p = 0; p < 4; p++) begin
        lf = lfsr_next(lf);
        plug_a <= p[0];
        plug_b <= p[1];
        volume_mute <= lf[3:0];
        bus(1, 8'h72, 16'(c) << 10);
        tick(3);
        m = mtab(c, p[1], p[0]);
        rd(8'h78, {8'h00, m[7:4], m[7:4] | (lf[3:0] & ~m[3:0])});
      end
    rd(8'h7a, 16'h0000);
    $display("mute matrix done");
    tick(3);
    close_out();
  end
endmodule

// ===== jack_sense_pkg.sv
// package: register map, field positions, reset values and timing for
// the jack sense and mute control block
// assumes a 16-bit register port and a single 25 MHz clock
package jack_sense_pkg;

  localparam int unsigned clk_hz = 25000000;
  localparam int unsigned qualify_ms = 278;
  localparam int unsigned qualify_cycles = (clk_hz / 1000) * qualify_ms;

  localparam logic [7:0] jack_sense_control_status_off = 8'h72;
  localparam logic [7:0] serial_configuration_off = 8'h74;
  localparam logic [7:0] jack_output_state_off = 8'h78;

  localparam logic [15:0] jack_sense_reset = 16'h0000;
  localparam logic [15:0] serial_configuration_reset = 16'h1001;
  localparam logic [15:0] serial_cfg_writable = 16'hfd77;

  localparam int unsigned bit_a_irq = 0;
  localparam int unsigned bit_b_irq = 1;
  localparam int unsigned bit_a_level = 2;
  localparam int unsigned bit_b_level = 3;
  localparam int unsigned bit_a_mode = 4;
  localparam int unsigned bit_a_qualify = 6;
  localparam int unsigned bit_a_eqb = 8;
  localparam int unsigned bit_mute_lo = 10;
  localparam int unsigned bit_a_dmx = 13;
  localparam int unsigned bit_b_dmx = 14;
  localparam int unsigned bit_spread = 15;
  localparam int unsigned bit_irq_path = 4;

  typedef struct packed {
    logic headphone_output;
    logic front_output;
    logic center_sub_output;
    logic mono_output;
  } forced_silence_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// ===== pin_qualifier.sv
// one sense pin: level taken as synchronous; optional long-high filter
// assumes the pin is already synchronous to ref_clk
`timescale 1ns/1ps
module pin_qualifier #(
  parameter int unsigned hold_cycles = 6950000
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic pin,
  input wire logic qualify_enable,
  output logic sensed
);
  import jack_sense_pkg::*;

  logic [31:0] count_reg;

  // counter restarts on any low or when filtering is off
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !pin || !qualify_enable) begin
      count_reg <= 32'h0;
    end else if (count_reg <= hold_cycles) begin
      count_reg <= count_reg + 32'h1;
    end
  end

  // strictly longer than the hold time before high is believed
  always_comb begin
    if (qualify_enable) begin
      sensed = pin && (count_reg > hold_cycles);
    end else begin
      sensed = pin;
    end
  end
endmodule
